// ---- testbench/tb.sv ----
// self-checking bench for the port phy control/status register bank
`timescale 1ns/1ns
`default_nettype none

module tb;
  import port_phy_regs_pkg::*;
  logic mclk_in, nrst_in, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] pstrb;
  phy_stat_t [NUM_PHY-1:0] phy_stat;
  logic [NUM_PHY-1:0] led0, led1, spd, dup, ind0, ind1;
  phy_ctrl_t [NUM_PHY-1:0] phy_ctrl;
  logic [NUM_MAC-1:0] mlb;
  logic [7:0] d;
  int fails, samples_checked, seed, cnt;

  port_phy_control_status_regs u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .phy_stat_in(phy_stat), .led0_raw_in(led0), .led1_raw_in(led1), .phy_ctrl_out(phy_ctrl),
    .port_speed_100_out(spd), .port_full_duplex_out(dup), .mac_loopback_out(mlb),
    .port_indicator_0_out(ind0), .port_indicator_1_out(ind1));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // pready is read before this edge's updates land, i.e. as sampled at the edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge mclk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_in);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
    return ADDR_W'(idx) << 2;
  endfunction : ba

  initial begin
    seed = 654;
    nrst_in = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, led0, led1} = '0;
    phy_stat = '0;
    pstrb = 4'hf;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    for (int p = 0; p < NUM_PHY; p++) begin
      chk("ctrl_out_rst", 32'(phy_ctrl_t'{1'b1, 1'b1, 1'b0, 5'h1f, 1'b0, 1'b0, 1'b1, 1'b0,
        1'b0}), 32'(phy_ctrl[p]));
      apb(1'b0, ba(IDX_CTRL5[p]), 8'h00);
      chk("ctrl5_rst", 32'h5f, rd);
      apb(1'b0, ba(IDX_CTRL6[p]), 8'h00);
      chk("ctrl6_rst", 32'h00, rd);
      apb(1'b0, ba(IDX_STAT1[p]), 8'h00);
      chk("stat_rst", 32'h00, rd);
    end
    $display("test reset_defaults done");
    // random forced/negotiated mode resolution, every combination of bits 7 and 5 in turn
    for (int i = 0; i < 16; i++) begin
      int p;
      p = i % 2;
      phy_stat <= 10'($random(seed));
      d = 8'($random(seed));
      if (i < 4) d[7:5] = {i[0], 1'b1, i[1]};
      apb(1'b1, ba(IDX_CTRL5[p]), d);
      apb(1'b0, ba(IDX_CTRL5[p]), 8'h00);
      chk("ctrl5_rb", {24'h0, d}, rd);
      repeat (4) @(posedge mclk_in);
      chk("speed", 32'(d[7] ? d[6] : phy_stat[p].speed_100), 32'(spd[p]));
      chk("duplex", 32'((d[7] | phy_stat[p].an_fail) ? d[5] : phy_stat[p].full_duplex),
        32'(dup[p]));
      chk("an_en", 32'(!d[7]), 32'(phy_ctrl[p].autoneg_en));
      chk("advert_hold", 32'h1f, 32'(phy_ctrl[p].advert));
      chk("forced_fields", 32'({d[6], d[5]}),
        32'({phy_ctrl[p].speed_100, phy_ctrl[p].full_duplex}));
      apb(1'b0, ba(IDX_STAT1[p]), 8'h00);
      chk("status", {24'h0, phy_stat[p].crossover, phy_stat[p].an_done, 6'h0}, rd);
    end
    $display("test mode_resolution done");
    // random misc control: leds, power-down, crossover, loopback
    for (int i = 0; i < 12; i++) begin
      int p;
      p = i % 2;
      led0 <= 2'($random(seed));
      led1 <= 2'($random(seed));
      d = 8'($random(seed)) & C6_PHY_MASK;
      apb(1'b1, ba(IDX_CTRL6[p]), d);
      apb(1'b0, ba(IDX_CTRL6[p]), 8'h00);
      chk("ctrl6_rb", {24'h0, d}, rd);
      repeat (4) @(posedge mclk_in);
      chk("led0", 32'(led0[p] | d[7]), 32'(ind0[p]));
      chk("led1", 32'(led1[p] | d[7]), 32'(ind1[p]));
      chk("pwr_dn", 32'(d[3]), 32'(phy_ctrl[p].power_down));
      chk("mdix_en", 32'(!d[2]), 32'(phy_ctrl[p].auto_mdix_en));
      chk("force_mdi", 32'(d[1]), 32'(phy_ctrl[p].force_mdi));
      chk("mac_lb", 32'(d[0]), 32'(mlb[p]));
    end
    $display("test misc_control done");
    // restart latches the new advertisement with one pulse, then self clears
    for (int p = 0; p < NUM_PHY; p++) begin
      d = 8'h80 | 8'($random(seed));
      apb(1'b1, ba(IDX_CTRL5[p]), d);
      apb(1'b1, ba(IDX_CTRL6[p]), 8'h20);
      cnt = 0;
      repeat (6) begin
        @(posedge mclk_in);
        if (phy_ctrl[p].restart === 1'b1) cnt++;
      end
      chk("restart_pulses", 32'd1, 32'(cnt));
      chk("advert_new", 32'(d[4:0]), 32'(phy_ctrl[p].advert));
      apb(1'b0, ba(IDX_CTRL6[p]), 8'h00);
      chk("restart_sc", 32'h0, rd);
    end
    $display("test restart done");
    // mac-only ports 3 and 4 keep loopback alone
    for (int p = 2; p < NUM_MAC; p++) begin
      apb(1'b1, ba(IDX_CTRL6[p]), 8'hff);
      apb(1'b0, ba(IDX_CTRL6[p]), 8'h00);
      chk("ctrl6_mac_rb", 32'h01, rd);
      repeat (4) @(posedge mclk_in);
      chk("mac_lb_34", 32'd1, 32'(mlb[p]));
    end
    apb(1'b0, 10'h000, 8'h00);
    chk("unmapped_err", 32'd1, 32'(err));
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, ba(IDX_STAT1[0]) | 10'h1, 8'hff);
    chk("misalign_err", 32'd1, 32'(err));
    $display("test refusals done");
    // mid-run reset acts at once, setting indicators high and clearing loopback; a write with its byte lane off is ignored
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk("rst_ind", 32'h3, 32'(ind0 & ind1));
    chk("rst_lb", 32'h0, 32'(mlb));
    nrst_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk("advert_rst", 32'h1f, 32'(phy_ctrl[0].advert));
    pstrb <= 4'h0;
    apb(1'b1, ba(IDX_CTRL5[0]), 8'h00);
    pstrb <= 4'hf;
    apb(1'b0, ba(IDX_CTRL5[0]), 8'h00);
    chk("strobe_masked", 32'h5f, rd);
    apb(1'b0, ba(IDX_CTRL6[2]), 8'h00);
    chk("ctrl6_rst_mac", 32'h0, rd);
    $display("test midrun_reset done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire

// ---- verilog/port_phy_control_status_regs.sv ----
// per-port phy control/status register bank behind an apb slave
`timescale 1ns/1ns
`default_nettype none

module port_phy_control_status_regs
  import port_phy_regs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire phy_stat_t [NUM_PHY-1:0] phy_stat_in,
  input wire logic [NUM_PHY-1:0] led0_raw_in,
  input wire logic [NUM_PHY-1:0] led1_raw_in,
  output phy_ctrl_t [NUM_PHY-1:0] phy_ctrl_out,
  output logic [NUM_PHY-1:0] port_speed_100_out,
  output logic [NUM_PHY-1:0] port_full_duplex_out,
  output logic [NUM_MAC-1:0] mac_loopback_out,
  output logic [NUM_PHY-1:0] port_indicator_0_out,
  output logic [NUM_PHY-1:0] port_indicator_1_out
);

  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  logic [NUM_PHY-1:0][7:0] ctrl5_r, ctrl5_nxt;
  logic [NUM_MAC-1:0][7:0] ctrl6_r, ctrl6_nxt;
  logic [NUM_PHY-1:0][7:0] stat1_r, stat1_nxt;
  logic [NUM_PHY-1:0][4:0] adv_r, adv_nxt;
  logic [NUM_PHY-1:0] restart_r, restart_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [7:0] idx;
  logic access, wr_en;
  logic [7:0] rd_data;
  logic hit;

  // one wait state keeps prdata and pready straight from flops
  assign idx = paddr_in[9:2];
  assign access = psel_in & penable_in & ~pready_out;
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out & pstrb_in[0];

  always_comb begin
    rd_data = 8'h00;
    hit = 1'b0;
    for (int p = 0; p < NUM_PHY; p++) begin
      if (idx == IDX_CTRL5[p]) begin
        rd_data = ctrl5_r[p];
        hit = 1'b1;
      end
      if (idx == IDX_STAT1[p]) begin
        rd_data = stat1_r[p];
        hit = 1'b1;
      end
    end
    for (int p = 0; p < NUM_MAC; p++) begin
      if (idx == IDX_CTRL6[p]) begin
        rd_data = ctrl6_r[p];
        hit = 1'b1;
      end
    end
    // restart lives in its own flop so the stored bit stays clear
    for (int p = 0; p < NUM_PHY; p++) begin
      if (idx == IDX_CTRL6[p]) begin
        rd_data[C6_RESTART] = restart_r[p];
      end
    end
    if (paddr_in[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  always_comb begin
    pready_nxt = access;
    pslverr_nxt = access & ~hit;
    prdata_nxt = 32'h0000_0000;
    if (access && hit && !pwrite_in) begin
      prdata_nxt = {24'h00_0000, rd_data};
    end
  end

  always_comb begin
    ctrl5_nxt = ctrl5_r;
    ctrl6_nxt = ctrl6_r;
    adv_nxt = adv_r;
    restart_nxt = '0;
    for (int p = 0; p < NUM_PHY; p++) begin
      stat1_nxt[p] = {phy_stat_in[p].crossover, phy_stat_in[p].an_done, 6'h00};
      // advertisement only moves when a negotiation is restarted
      if (restart_r[p]) begin
        adv_nxt[p] = ctrl5_r[p][C5_ADV_MSB:0];
      end
      if (wr_en && idx == IDX_CTRL5[p]) begin
        ctrl5_nxt[p] = pwdata_in[7:0];
      end
    end
    for (int p = 0; p < NUM_PHY; p++) begin
      if (wr_en && idx == IDX_CTRL6[p]) begin
        ctrl6_nxt[p] = pwdata_in[7:0] & C6_PHY_MASK;
        restart_nxt[p] = pwdata_in[C6_RESTART];
      end
    end
    for (int p = NUM_PHY; p < NUM_MAC; p++) begin
      if (wr_en && idx == IDX_CTRL6[p]) begin
        ctrl6_nxt[p] = pwdata_in[7:0] & C6_MAC_MASK;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl5_r <= {NUM_PHY{CTRL5_RST}};
      ctrl6_r <= {NUM_MAC{CTRL6_RST}};
      stat1_r <= {NUM_PHY{STAT1_RST}};
      adv_r <= {NUM_PHY{CTRL5_RST[C5_ADV_MSB:0]}};
      restart_r <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      ctrl5_r <= ctrl5_nxt;
      ctrl6_r <= ctrl6_nxt;
      stat1_r <= stat1_nxt;
      adv_r <= adv_nxt;
      restart_r <= restart_nxt;
      pready_out <= pready_nxt;
      pslverr_out <= pslverr_nxt;
      prdata_out <= prdata_nxt;
    end
  end

  phy_ctrl_t [NUM_PHY-1:0] ctrl_o_nxt;
  logic [NUM_PHY-1:0] spd_nxt, dup_nxt, ind0_nxt, ind1_nxt;
  logic [NUM_MAC-1:0] lb_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_PHY; g++) begin : g_port
      always_comb begin
        ctrl_o_nxt[g].autoneg_en = ~ctrl5_r[g][C5_AN_DIS];
        ctrl_o_nxt[g].speed_100 = ctrl5_r[g][C5_SPEED];
        ctrl_o_nxt[g].full_duplex = ctrl5_r[g][C5_DUPLEX];
        ctrl_o_nxt[g].advert = adv_r[g];
        ctrl_o_nxt[g].restart = restart_r[g];
        ctrl_o_nxt[g].power_down = ctrl6_r[g][C6_PWR_DN];
        ctrl_o_nxt[g].auto_mdix_en = ~ctrl6_r[g][C6_MDIX_DIS];
        ctrl_o_nxt[g].force_mdi = ctrl6_r[g][C6_FORCE_MDI];
        ctrl_o_nxt[g].tx_disable = ctrl6_r[g][C6_TX_DIS];
        // forced speed only when autoneg is off; failed autoneg keeps detected speed
        spd_nxt[g] = ctrl5_r[g][C5_AN_DIS] ? ctrl5_r[g][C5_SPEED] :
                     phy_stat_in[g].speed_100;
        dup_nxt[g] = (ctrl5_r[g][C5_AN_DIS] | phy_stat_in[g].an_fail) ?
                     ctrl5_r[g][C5_DUPLEX] : phy_stat_in[g].full_duplex;
        ind0_nxt[g] = led0_raw_in[g] | ctrl6_r[g][C6_LED_OFF];
        ind1_nxt[g] = led1_raw_in[g] | ctrl6_r[g][C6_LED_OFF];
      end
    end
    for (g = 0; g < NUM_MAC; g++) begin : g_mac
      // loop path to the monitor port is steered by the switch fabric
      assign lb_nxt[g] = ctrl6_r[g][C6_MAC_LB];
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      phy_ctrl_out <= '0;
      port_speed_100_out <= '0;
      port_full_duplex_out <= '0;
      mac_loopback_out <= '0;
      port_indicator_0_out <= '1;
      port_indicator_1_out <= '1;
    end else begin
      phy_ctrl_out <= ctrl_o_nxt;
      port_speed_100_out <= spd_nxt;
      port_full_duplex_out <= dup_nxt;
      mac_loopback_out <= lb_nxt;
      port_indicator_0_out <= ind0_nxt;
      port_indicator_1_out <= ind1_nxt;
    end
  end

  a_forced_speed_sel: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl5_r[0][C5_AN_DIS] |=> port_speed_100_out[0] == $past(ctrl5_r[0][C5_SPEED]))
    else $error("forced speed not applied");

  a_forced_duplex_sel: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (ctrl5_r[0][C5_AN_DIS] || phy_stat_in[0].an_fail)
      |=> port_full_duplex_out[0] == $past(ctrl5_r[0][C5_DUPLEX]))
    else $error("forced duplex not applied");

  a_restart_self_clear: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (wr_en && idx == IDX_CTRL6[0] && pwdata_in[C6_RESTART])
      |=> restart_r[0] ##1 (!restart_r[0] && phy_ctrl_out[0].restart) ##1 !phy_ctrl_out[0].restart)
    else $error("restart pulse wrong");

  a_advert_on_restart: assert property (@(posedge mclk_in) disable iff (!rst_n)
    restart_r[0] |=> ##1 phy_ctrl_out[0].advert == $past(ctrl5_r[0][C5_ADV_MSB:0], 2))
    else $error("advertisement not loaded at restart");

  a_advert_held: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !restart_r[0] |=> $stable(adv_r[0]))
    else $error("advertisement changed without restart");

  a_led_blank_high: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl6_r[0][C6_LED_OFF] |=> (port_indicator_0_out[0] && port_indicator_1_out[0]))
    else $error("leds not blanked");

  a_power_down_follow: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $rose(ctrl6_r[0][C6_PWR_DN]) |=> phy_ctrl_out[0].power_down)
    else $error("power-down not applied");

  a_mdix_force: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl6_r[0][C6_MDIX_DIS]
      |=> (!phy_ctrl_out[0].auto_mdix_en
           && phy_ctrl_out[0].force_mdi == $past(ctrl6_r[0][C6_FORCE_MDI])))
    else $error("crossover control wrong");

  a_loopback_ports: assert property (@(posedge mclk_in) disable iff (!rst_n)
    1'b1 |=> mac_loopback_out[3] == $past(ctrl6_r[3][C6_MAC_LB]))
    else $error("loopback bit not driven");

  a_status_read: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (access && !pwrite_in && idx == IDX_STAT1[0] && paddr_in[1:0] == 2'b00)
      |=> (pready_out && prdata_out[7:6] == $past(stat1_r[0][7:6])))
    else $error("status read wrong");

  a_apb_one_wait: assert property (@(posedge mclk_in) disable iff (!rst_n)
    access |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

  a_forced_speed_p2: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ctrl5_r[1][C5_AN_DIS] |=> port_speed_100_out[1] == $past(ctrl5_r[1][C5_SPEED]))
    else $error("forced speed not applied on second port");

  a_autoneg_speed: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !ctrl5_r[0][C5_AN_DIS]
      |=> port_speed_100_out[0] == $past(phy_stat_in[0].speed_100))
    else $error("negotiated speed not passed through");

  a_negotiated_duplex: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (!ctrl5_r[0][C5_AN_DIS] && !phy_stat_in[0].an_fail)
      |=> port_full_duplex_out[0] == $past(phy_stat_in[0].full_duplex))
    else $error("negotiated duplex not passed through");

  a_advert_restart_p2: assert property (@(posedge mclk_in) disable iff (!rst_n)
    restart_r[1] |=> ##1 phy_ctrl_out[1].advert == $past(ctrl5_r[1][C5_ADV_MSB:0], 2))
    else $error("advertisement not loaded at restart on second port");

  a_loopback_bits: assert property (@(posedge mclk_in) disable iff (!rst_n)
    1'b1 |=> (mac_loopback_out[0] == $past(ctrl6_r[0][C6_MAC_LB])
              && mac_loopback_out[2] == $past(ctrl6_r[2][C6_MAC_LB])))
    else $error("loopback bits not driven");

  a_led_follow_raw: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !ctrl6_r[1][C6_LED_OFF]
      |=> (port_indicator_0_out[1] == $past(led0_raw_in[1])
           && port_indicator_1_out[1] == $past(led1_raw_in[1])))
    else $error("leds not following raw levels");

  a_status_sample: assert property (@(posedge mclk_in) disable iff (!rst_n)
    1'b1 |=> stat1_r[1][ST_MDIX:ST_AN_DONE]
      == $past({phy_stat_in[1].crossover, phy_stat_in[1].an_done}))
    else $error("status not sampled");

  a_restart_no_spur: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !restart_r[1] |=> !phy_ctrl_out[1].restart)
    else $error("restart pulse without request");

  a_power_down_p2: assert property (@(posedge mclk_in) disable iff (!rst_n)
    1'b1 |=> phy_ctrl_out[1].power_down == $past(ctrl6_r[1][C6_PWR_DN]))
    else $error("power-down not applied on second port");

endmodule : port_phy_control_status_regs

`default_nettype wire

// ---- verilog/port_phy_regs_pkg.sv ----
// constants, register map and carrier types for the port phy control bank
package port_phy_regs_pkg;

  localparam int NUM_PHY = 2;
  localparam int NUM_MAC = 4;
  localparam int ADDR_W = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL5 [NUM_PHY] = '{8'h2c, 8'h3c};
  localparam logic [7:0] IDX_CTRL6 [NUM_MAC] = '{8'h2d, 8'h3d, 8'h4d, 8'h5d};
  localparam logic [7:0] IDX_STAT1 [NUM_PHY] = '{8'h2e, 8'h3e};

  // autoneg / advertisement control fields
  localparam int C5_AN_DIS = 7;
  localparam int C5_SPEED = 6;
  localparam int C5_DUPLEX = 5;
  localparam int C5_ADV_MSB = 4;
  localparam logic [7:0] CTRL5_RST = 8'h5f;

  // misc phy control fields
  localparam int C6_LED_OFF = 7;
  localparam int C6_TX_DIS = 6;
  localparam int C6_RESTART = 5;
  localparam int C6_PWR_DN = 3;
  localparam int C6_MDIX_DIS = 2;
  localparam int C6_FORCE_MDI = 1;
  localparam int C6_MAC_LB = 0;
  localparam logic [7:0] CTRL6_RST = 8'h00;
  localparam logic [7:0] C6_PHY_MASK = 8'hcf;
  localparam logic [7:0] C6_MAC_MASK = 8'h01;

  // status fields
  localparam int ST_MDIX = 7;
  localparam int ST_AN_DONE = 6;
  localparam logic [7:0] STAT1_RST = 8'h00;

  localparam int MONITOR_PORT = 2;

  // advert[4] pause, [3] 100 fd, [2] 100 hd, [1] 10 fd, [0] 10 hd
  typedef struct packed {
    logic autoneg_en;
    logic speed_100;
    logic full_duplex;
    logic [4:0] advert;
    logic restart;
    logic power_down;
    logic auto_mdix_en;
    logic force_mdi;
    logic tx_disable;
  } phy_ctrl_t;

  typedef struct packed {
    logic crossover;
    logic an_done;
    logic an_fail;
    logic speed_100;
    logic full_duplex;
  } phy_stat_t;

endpackage : port_phy_regs_pkg
